// >>> pkg/sensor_regs.vh
// constants for the humidity and temperature sensor command port
// Function
// RL1: ready for commands within 20 ms
// RL2: host frames transfers with start, stop
// RL3: sda falls while scl high: start
// RL4: sda rises while scl high: stop
// RL5: first byte address 0x38 plus direction
// RL6: acknowledge each byte after eighth fall
// RL7: byte 0xE1 means initialization
// RL8: byte 0xAC triggers one measurement
// RL9: host waits for measurement completion
// RL10: byte 0xBA restarts, restores defaults
// RL11: soft reset completes within 20 ms
// RL12: status bit 7 shows busy
// RL13: status bits 6:5 show mode
// RL14: status bit 3 shows calibration
// RL15: host waits over 75 ms
// RL16: host polls until busy clears
// RL17: humidity equals raw over 2^20 times 100
// RL18: temperature equals raw over 2^20 times 200 minus 50
// RL19: trigger write carries 0x33, 0x00 parameters
// RL20: read returns status, humidity, temperature
// RL21: sda changes only while scl low
// RL22: fully static, no minimum scl rate
`ifndef SENSOR_REGS_VH
`define SENSOR_REGS_VH
// ==========================================================
// bus protocol
`define TARGET_ADDR 7'h38
`define CMD_INIT 8'hE1
`define CMD_TRIG 8'hAC
`define CMD_SRST 8'hBA
// ==========================================================
// status byte fields
`define ST_BUSY_BIT 7
`define ST_MODE_HI 6
`define ST_MODE_LO 5
`define ST_CAL_BIT 3
`define MODE_NORMAL 2'b00
`define MODE_CYCLIC 2'b01
`define MODE_CMD 2'b10
// ==========================================================
// timing (clock 4 ns)
`define CLK_PERIOD_NS 4
`define READY_TIME_MS 20
`define READY_CYCLES ((`READY_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define MEAS_TIME_MS 75
`define MEAS_CYCLES ((`MEAS_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define READ_BYTES 4'd6
`endif

// >>> core/pin_sync.v
// two-flop synchroniser for the bus pins
module pin_sync (
  input wire clk,
  input wire rst,
  input wire d,
  output reg q
);
  reg meta_q;
  // ==========================================================
  // bus idles high, so reset to one
  always @(posedge clk) begin
    if (rst) begin
      meta_q <= 1'b1;
      q <= 1'b1;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// >>> core/sensor_port.v
// i2c target command port of the humidity and temperature sensor
`include "sensor_regs.vh"
module sensor_port #(
  parameter [31:0] READY_CYCLES = `READY_CYCLES,
  parameter [31:0] MEAS_CYCLES = `MEAS_CYCLES
) (
  input wire SYS_CLK,
  input wire RST,
  input wire SCL_IN,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  input wire [19:0] RAW_HUMIDITY_WORD,
  input wire [19:0] RAW_TEMPERATURE_WORD,
  input wire [1:0] MODE_IN,
  input wire CAL_VALID,
  output reg READY,
  output reg BUSY,
  output reg SOFT_RESET_PULSE
);
  // ==========================================================
  // states
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_RECV = 4'b0010;
  localparam [3:0] S_SEND = 4'b0100;
  localparam [3:0] S_ACK = 4'b1000;
  reg [3:0] state_q;
  // driven by the synchroniser instances, so nets rather than registers
  wire scl_s;
  wire sda_s;
  reg scl_p_q;
  reg sda_p_q;
  reg [7:0] shift_q;
  reg [3:0] bit_q;
  reg [3:0] byte_q;
  reg rd_q;
  reg ack_drv_q;
  reg [31:0] ready_cnt_q;
  reg [31:0] meas_cnt_q;
  reg [39:0] data_q;
  reg master_ack_q;
  wire scl_rise, scl_fall, start_ev, stop_ev;
  wire [7:0] status_byte;
  wire [7:0] next_byte;

  pin_sync u_scl (.clk(SYS_CLK), .rst(RST), .d(SCL_IN), .q(scl_s));
  pin_sync u_sda (.clk(SYS_CLK), .rst(RST), .d(SDA_IN), .q(sda_s));

  // ==========================================================
  // edge and condition detection on synchronised pins
  always @(posedge SYS_CLK) begin
    if (RST) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  // RL3: start detection
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  // RL4: stop detection
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // RL12: busy in bit 7, RL13 mode, RL14 calibration
  assign status_byte = {BUSY, MODE_IN, 1'b0, CAL_VALID, 3'b000};

  // byte picked from status plus 40-bit packed results
  function [7:0] pick_byte;
    input [3:0] idx;
    input [7:0] st;
    input [39:0] dat;
    begin
      case (idx)
        4'd0: pick_byte = st;
        4'd1: pick_byte = dat[39:32];
        4'd2: pick_byte = dat[31:24];
        4'd3: pick_byte = dat[23:16];
        4'd4: pick_byte = dat[15:8];
        4'd5: pick_byte = dat[7:0];
        default: pick_byte = 8'hFF;
      endcase
    end
  endfunction

  // one pick shared by the ack and next-byte paths; bit 7 goes out first
  assign next_byte = pick_byte(byte_q, status_byte, data_q);

  // ==========================================================
  // ready and measurement timers
  always @(posedge SYS_CLK) begin
    if (RST) begin
      ready_cnt_q <= 32'h0000_0000;
      READY <= 1'b0;
      meas_cnt_q <= 32'h0000_0000;
      BUSY <= 1'b0;
      SOFT_RESET_PULSE <= 1'b0;
      data_q <= 40'h00_0000_0000;
    end else begin
      SOFT_RESET_PULSE <= 1'b0;
      // RL1: power-up ready delay, RL11 same after soft reset
      if (!READY) begin
        if (ready_cnt_q >= READY_CYCLES - 32'h0000_0001)
          READY <= 1'b1;
        ready_cnt_q <= ready_cnt_q + 32'h0000_0001;
      end
      if (BUSY) begin
        if (meas_cnt_q >= MEAS_CYCLES - 32'h0000_0001) begin
          BUSY <= 1'b0;
          // RL20: humidity then temperature, msb first
          data_q <= {RAW_HUMIDITY_WORD, RAW_TEMPERATURE_WORD};
        end
        meas_cnt_q <= meas_cnt_q + 32'h0000_0001;
      end
      // command taken on the last data bit of byte 1 of a write
      if (state_q == S_RECV && scl_rise && bit_q == 4'd7 && byte_q == 4'd1
          && !rd_q && READY) begin
        // RL8: trigger a measurement
        if ({shift_q[6:0], sda_s} == `CMD_TRIG && !BUSY) begin
          BUSY <= 1'b1;
          meas_cnt_q <= 32'h0000_0000;
        end
        // RL10: soft reset restores defaults
        if ({shift_q[6:0], sda_s} == `CMD_SRST) begin
          READY <= 1'b0;
          ready_cnt_q <= 32'h0000_0000;
          BUSY <= 1'b0;
          SOFT_RESET_PULSE <= 1'b1;
          data_q <= 40'h00_0000_0000;
        end
        // RL7: initialization accepted, no further action here
      end
    end
  end

  // ==========================================================
  // byte engine; state advances only on scl edges and start or stop conditions, so no minimum scl rate applies
  // RL22: fully static operation
  always @(posedge SYS_CLK) begin
    if (RST) begin
      state_q <= S_IDLE;
      shift_q <= 8'h00;
      bit_q <= 4'd0;
      byte_q <= 4'd0;
      rd_q <= 1'b0;
      ack_drv_q <= 1'b0;
      master_ack_q <= 1'b0;
      SDA_OUT <= 1'b1;
      SDA_OE <= 1'b0;
    end else if (stop_ev) begin
      // RL4: stop returns to idle
      state_q <= S_IDLE;
      SDA_OE <= 1'b0;
    end else if (start_ev) begin
      state_q <= READY ? S_RECV : S_IDLE;
      bit_q <= 4'd0;
      byte_q <= 4'd0;
      SDA_OE <= 1'b0;
    end else begin
      case (state_q)
        S_RECV: begin
          if (scl_rise) begin
            shift_q <= {shift_q[6:0], sda_s};
            bit_q <= bit_q + 4'd1;
          end
          if (scl_fall && bit_q == 4'd8) begin
            // RL5: address match and direction bit
            if (byte_q == 4'd0 && shift_q[7:1] != `TARGET_ADDR) begin
              state_q <= S_IDLE;
            end else begin
              if (byte_q == 4'd0)
                rd_q <= shift_q[0];
              // RL6: pull sda low for acknowledge
              SDA_OUT <= 1'b0;
              SDA_OE <= 1'b1;
              ack_drv_q <= 1'b0;
              state_q <= S_ACK;
            end
          end
        end
        S_ACK: begin
          if (scl_rise)
            ack_drv_q <= 1'b1;
          if (scl_fall && ack_drv_q) begin
            bit_q <= 4'd0;
            byte_q <= byte_q + 4'd1;
            if (rd_q) begin
              // RL21: change sda only after scl falls
              shift_q <= next_byte;
              SDA_OUT <= next_byte[7];
              SDA_OE <= ~next_byte[7];
              state_q <= S_SEND;
            end else begin
              SDA_OE <= 1'b0;
              SDA_OUT <= 1'b1;
              state_q <= S_RECV;
            end
          end
        end
        S_SEND: begin
          if (scl_rise) begin
            bit_q <= bit_q + 4'd1;
            if (bit_q == 4'd8)
              master_ack_q <= ~sda_s;
          end
          if (scl_fall) begin
            if (bit_q < 4'd8) begin
              // open drain: drive only zeros; the seventh fall puts out bit 0
              SDA_OUT <= shift_q[6];
              SDA_OE <= ~shift_q[6];
              shift_q <= {shift_q[6:0], 1'b1};
            end else if (bit_q == 4'd8) begin
              // let go after bit 0 so the host can answer
              SDA_OE <= 1'b0;
              SDA_OUT <= 1'b1;
            end else if (bit_q == 4'd9) begin
              if (master_ack_q && byte_q < `READ_BYTES) begin
                bit_q <= 4'd0;
                byte_q <= byte_q + 4'd1;
                shift_q <= next_byte;
                SDA_OUT <= next_byte[7];
                SDA_OE <= ~next_byte[7];
              end else begin
                state_q <= S_IDLE;
                SDA_OE <= 1'b0;
              end
            end
          end
        end
        S_IDLE: begin
          SDA_OE <= 1'b0;
          SDA_OUT <= 1'b1;
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// >>> tb/sensor_port_properties.sv
// pin-level checks on the sensor command port
module sensor_port_props #(
  parameter [31:0] READY_CYCLES = 20,
  parameter [31:0] MEAS_CYCLES = 400
) (
  input logic SYS_CLK,
  input logic RST,
  input logic SCL_IN,
  input logic SDA_OUT,
  input logic SDA_OE,
  input logic READY,
  input logic BUSY,
  input logic SOFT_RESET_PULSE
);
  // ================================
  // one domain; reset masks every check
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_oe_drives_low: assert property (SDA_OE |-> !SDA_OUT)
    else $error("data pin driven high");
  a_oe_scl_low: assert property ($changed(SDA_OE) |-> !SCL_IN)
    else $error("data pin moved while bus clock high");
  a_ready_delay: assert property ($fell(RST) |-> !READY[*8] ##[1:30] READY)
    else $error("ready delay wrong");
  a_ready_fall: assert property ($fell(READY) |-> SOFT_RESET_PULSE ||
    $past(SOFT_RESET_PULSE) || $past(SOFT_RESET_PULSE, 2))
    else $error("ready dropped without soft reset");
  a_pulse_single: assert property (SOFT_RESET_PULSE |=> !SOFT_RESET_PULSE)
    else $error("soft reset pulse too long");
  a_busy_ready: assert property ($rose(BUSY) |-> READY)
    else $error("measurement started before ready");
  a_busy_span: assert property ($rose(BUSY) |=> BUSY[*8])
    else $error("busy too short");
  a_busy_ends: assert property ($rose(BUSY) |-> ##[1:450] !BUSY)
    else $error("busy never ends");
endmodule

bind sensor_port sensor_port_props #(.READY_CYCLES(READY_CYCLES), .MEAS_CYCLES(MEAS_CYCLES))
  sensor_port_props_i (.SYS_CLK(SYS_CLK), .RST(RST), .SCL_IN(SCL_IN), .SDA_OUT(SDA_OUT),
  .SDA_OE(SDA_OE), .READY(READY), .BUSY(BUSY), .SOFT_RESET_PULSE(SOFT_RESET_PULSE));

// >>> tb/i2c_host.sv
// bus controller model: drives the bus clock, pulls data low
module i2c_host (
  input logic clk,
  input logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ================================
  // clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // quarter of the 32 ns bus period
  task automatic q;
    repeat (2) @(negedge clk);
  endtask
  task automatic start;
    sda_low = 1'b1;
    q;
    scl = 1'b0;
    q;
  endtask
  task automatic stop;
    sda_low = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_low = 1'b0;
    q;
  endtask
  // data moves only while clock low
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    q;
    scl = 1'b1;
    q;
    r = sda;
    q;
    scl = 1'b0;
    q;
  endtask
  // eight bits then the acknowledge slot
  task automatic xfer(input logic [7:0] o, input logic a, output logic [7:0] r,
    output logic k);
    for (int i = 7; i >= 0; i--)
      bit_io(o[i], r[i]);
    bit_io(a, k);
  endtask
endmodule

// >>> tb/test_sensor_port.sv
// self-checking bench for the sensor command port
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
  $display("ERROR at %0t: got %h expected %h", $time, a, e); end end
module test_sensor_port;
  timeunit 1ns;
  timeprecision 1ps;
  // ================================
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic scl, host_low, sda, sda_out, sda_oe, cal, ready, busy, pulse, k;
  logic pulse_seen = 1'b0;
  logic [19:0] hum = 20'hA_5C3E;
  logic [19:0] tmp = 20'h1_B7F4;
  logic [1:0] mode = 2'h0;
  logic [7:0] r [6];
  int failures = 0;
  int checks_done = 0;
  // released line reads high through the pull-up
  assign sda = !host_low && (!sda_oe || sda_out);
  initial forever #2 clk = ~clk;
  // the pulse lasts one cycle, so latch it
  always @(posedge clk) if (pulse) pulse_seen <= 1'b1;
  sensor_port #(.READY_CYCLES(32'h0000_0014), .MEAS_CYCLES(32'h0000_0190)) sensor_port_i (
    .SYS_CLK(clk), .RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .RAW_HUMIDITY_WORD(hum), .RAW_TEMPERATURE_WORD(tmp),
    .MODE_IN(mode), .CAL_VALID(cal), .READY(ready), .BUSY(busy),
    .SOFT_RESET_PULSE(pulse));
  i2c_host i2c_host_i (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic [7:0] b);
    i2c_host_i.xfer(b, 1'b1, r[0], k);
    `CHK(k, 1'b0)
  endtask
  task automatic wr(input logic [7:0] c, input logic par);
    i2c_host_i.start();
    wb(8'h70);
    wb(c);
    if (par) begin
      wb(8'h33);
      wb(8'h00);
    end
    i2c_host_i.stop();
  endtask
  task automatic rd(input int n);
    i2c_host_i.start();
    wb(8'h71);
    for (int i = 0; i < n; i++)
      i2c_host_i.xfer(8'hFF, i == n - 1, r[i], k);
    i2c_host_i.stop();
  endtask
  // bounded wait on ready high or busy low; a hang ends the run
  task automatic hold(input logic want_ready);
    int n;
    for (n = 0; n < 600 && (want_ready ? ready !== 1'b1 : busy !== 1'b0); n++)
      @(negedge clk);
    if (n == 600) begin
      failures++;
      give_verdict();
    end
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    // a frame opened before ready is ignored
    i2c_host_i.start();
    i2c_host_i.xfer(8'h70, 1'b1, r[0], k);
    `CHK(k, 1'b1)
    i2c_host_i.stop();
    hold(1'b1);
    i2c_host_i.start();
    i2c_host_i.xfer(8'h72, 1'b1, r[0], k);
    `CHK(k, 1'b1)
    i2c_host_i.stop();
    $display("test address done");
    for (int m = 0; m < 4; m++) begin
      mode = m[1:0];
      cal = m[0];
      rd(1);
      `CHK(r[0] & 8'hE8, {1'b0, m[1:0], 1'b0, m[0], 3'h0})
    end
    $display("test status done");
    wr(8'hE1, 1'b0);
    `CHK(busy, 1'b0)
    wr(8'hAC, 1'b1);
    `CHK(busy, 1'b1)
    rd(1);
    `CHK(r[0][7], 1'b1)
    hold(1'b0);
    rd(6);
    for (int i = 1; i < 6; i++)
      `CHK(r[i], ({hum, tmp} >> (40 - 8 * i)) & 40'h00_0000_00FF)
    // host-side scaling of the words read back
    `CHK(({r[1], r[2], r[3][7:4]} * 64'h0064) >> 20, 64'h0040)
    `CHK((({r[3][3:0], r[4], r[5]} * 64'h00C8) >> 20) - 64'h0032, 64'hFFFF_FFFF_FFFF_FFE3)
    $display("test measure done");
    i2c_host_i.start();
    wb(8'h70);
    i2c_host_i.xfer(8'hBA, 1'b1, r[0], k);
    i2c_host_i.stop();
    `CHK(pulse_seen, 1'b1)
    hold(1'b1);
    rd(2);
    `CHK(r[1], 8'h00)
    $display("test soft reset done");
    give_verdict();
  end
endmodule
